// ### psil_pkg.sv
package psil_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 8;
    // strobe pulse width on an output port
    localparam int unsigned STROBE_PULSE_NS = 100;
    localparam int unsigned STROBE_CYC      = (STROBE_PULSE_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
    // longest internal programming cycle, 5 ms
    localparam int unsigned WRITE_CYCLE_NS  = 5_000_000;
    localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_NS / CLK_PERIOD_NS;

    localparam int unsigned APB_AW = 8;

    // register byte offsets
    localparam logic [7:0] OFS_IRQ_STAT = 8'h00;
    localparam logic [7:0] OFS_CONFIG   = 8'h04;
    localparam logic [7:0] OFS_LATCH_A  = 8'h08;
    localparam logic [7:0] OFS_PINS_A   = 8'h0c;
    localparam logic [7:0] OFS_LATCH_B  = 8'h10;
    localparam logic [7:0] OFS_PINS_B   = 8'h14;
    localparam logic [7:0] OFS_PROG     = 8'h18;
    localparam logic [7:0] OFS_STAT     = 8'h1c;

    // interrupt status register fields
    localparam int unsigned IRQ_FLAG_A   = 0;
    localparam int unsigned IRQ_FLAG_B   = 1;
    localparam int unsigned IRQ_INT      = 2;
    localparam int unsigned IRQ_DONE     = 3;
    localparam int unsigned IRQ_EN_A     = 4;
    localparam int unsigned IRQ_EN_B     = 5;
    localparam int unsigned IRQ_EN_DONE  = 6;
    // configuration register fields, then programming register plane and toggle bits
    localparam int unsigned CFG_DIR      = 0;
    localparam int unsigned CFG_WO       = 2;
    localparam int unsigned CFG_POL      = 4;
    localparam int unsigned CFG_CLR_METH = 6;
    localparam int unsigned PROG_PLANE   = 8;
    localparam int unsigned TOGGLE_BIT   = 6;

    localparam logic [6:0] CFG_RESET    = 7'h00;
    localparam logic [2:0] IRQ_EN_RESET = 3'h0;

    typedef struct packed {
        logic       flag_clear_method;
        logic [1:0] strobe_polarity_n;
        logic [1:0] wire_or;
        logic [1:0] dir_out;
    } psil_cfg_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0]       pwdata;
    } psil_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } psil_apb_rsp_t;

    typedef enum logic [1:0] {
        PSIL_IDLE = 2'b00,
        PSIL_RUN  = 2'b01,
        PSIL_DONE = 2'b11
    } psil_prog_state_t;

endpackage

// ### psil_prog_timer.sv
`timescale 1ns/100ps
module psil_prog_timer #(
    parameter int unsigned CYCLES = psil_pkg::WRITE_CYCLE_CYC
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_start,
    input  wire logic       i_plane,
    output logic      [1:0] o_busy,
    output logic            o_done
);
    import psil_pkg::*;

    psil_prog_state_t state;
    logic [31:0]      cnt;
    logic             plane;

    if (CYCLES < 2) begin : g_chk
        $error("programming cycle too short");
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= PSIL_IDLE;
            cnt   <= 32'h0;
            plane <= 1'b0;
        end else begin
            case (state)
                PSIL_IDLE: begin
                    if (i_start) begin
                        state <= PSIL_RUN;
                        cnt   <= CYCLES - 1;
                        plane <= i_plane;
                    end
                end
                PSIL_RUN: begin
                    if (cnt == 32'h1) begin
                        state <= PSIL_DONE;
                    end
                    cnt <= cnt - 32'h1;
                end
                PSIL_DONE: state <= PSIL_IDLE;
                default:   state <= PSIL_IDLE;
            endcase
        end
    end

    // only the plane under programming is reported busy
    assign o_busy = (state == PSIL_IDLE) ? 2'h0 : (plane ? 2'h2 : 2'h1);
    assign o_done = (state == PSIL_DONE);

endmodule

// ### psil_top.sv
`timescale 1ns/100ps
// Contract
// - output port never raises its flag
// - input strobe edge latches pins, sets flag
// - per-port enable masks its interrupt request
// - clearing pending flags releases interrupt request
// - method one: flag cleared by writing zero
// - method zero: data latch read clears flag
// - latch clock is strobe xor polarity
// - strobe equals polarity: latch is transparent
// - polarity flip freezes pins and sets flag
// - programming plane shows busy, other plane not; any new byte refused until done
// - bit six toggles on reads while programming
// - programming end sets write done flag
// - write done enable asserts interrupt request
// - write done flag cleared only writing zero
// - bidirectional strobe stays output, not clock
// - interrupt request is active-low open drain
// - port flag set with global flag
// - output write updates pins, pulses strobe
module psil_top #(
    parameter int unsigned WRITE_CYCLES = psil_pkg::WRITE_CYCLE_CYC
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst_n,
    input  wire psil_pkg::psil_apb_req_t i_apb,
    output psil_pkg::psil_apb_rsp_t      o_apb,
    input  wire logic [1:0][7:0]         i_port_pin,
    output logic      [1:0][7:0]         o_port_pin,
    output logic      [1:0][7:0]         o_port_pin_oe,
    input  wire logic [1:0]              i_strobe_pin,
    output logic      [1:0]              o_strobe_pin,
    output logic      [1:0]              o_strobe_pin_oe,
    output logic                         o_irq_n,
    output logic                         o_irq_n_oe,
    output logic      [1:0]              o_plane_busy,
    output logic      [8:0]              o_prog_data
);
    import psil_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    psil_cfg_t       cfg;
    logic [1:0]      port_irq_enable;
    logic            write_done_irq_enable;
    logic [1:0]      port_n_irq_flag;
    logic [1:0]      next_port_flag;
    logic            int_flag;
    logic            write_done_flag;
    logic            next_write_done;
    logic [1:0][7:0] port_data_latch;
    logic [1:0][7:0] pin_s1;
    logic [1:0][7:0] pin_s2;
    logic [1:0]      strobe_pin_b_s1;
    logic [1:0]      strobe_pin_b_s2;
    logic [1:0]      latch_clk;
    logic [1:0]      latch_clk_q;
    logic [1:0]      cap_edge;
    logic [1:0][7:0] stb_cnt;
    logic [8:0]      prog_reg;
    logic            toggle_q;
    logic [1:0]      busy;
    logic            prog_done;
    logic            prog_start;
    logic [31:0]     next_rdata;
    logic            next_err;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: one wait state, effects land on the pready edge

    logic       acc;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wd;
    logic       wr_irq_st;
    logic [1:0] rd_latch;
    logic [1:0] wr_latch;
    logic       rd_prog;

    assign acc     = i_apb.psel && i_apb.penable && o_apb.pready;
    assign wr      = acc && i_apb.pwrite;
    assign rd      = acc && !i_apb.pwrite;
    assign addr    = 8'(i_apb.paddr);
    assign wd      = i_apb.pwdata[7:0];
    assign wr_irq_st = wr && (addr == OFS_IRQ_STAT);
    assign rd_latch  = {rd && (addr == OFS_LATCH_B), rd && (addr == OFS_LATCH_A)};
    assign wr_latch  = {wr && (addr == OFS_LATCH_B), wr && (addr == OFS_LATCH_A)};
    assign rd_prog = rd && (addr == OFS_PROG);
    // a new byte is refused while a programming cycle still runs
    assign prog_start = wr && (addr == OFS_PROG) && (busy == 2'h0);

    always_comb begin
        next_rdata = 32'h0;
        next_err   = 1'b0;
        case (addr)
            OFS_IRQ_STAT: next_rdata[7:0] = {1'b0, write_done_irq_enable, port_irq_enable,
                                             write_done_flag, int_flag, port_n_irq_flag};
            OFS_CONFIG:   next_rdata[7:0] = {1'b0, cfg};
            OFS_LATCH_A:  next_rdata[7:0] = port_data_latch[0];
            OFS_PINS_A:   next_rdata[7:0] = pin_s2[0];
            OFS_LATCH_B:  next_rdata[7:0] = port_data_latch[1];
            OFS_PINS_B:   next_rdata[7:0] = pin_s2[1];
            OFS_PROG: begin
                next_rdata[8:0] = prog_reg;
                if (busy != 2'h0) begin
                    next_rdata[TOGGLE_BIT] = toggle_q;
                end
            end
            OFS_STAT:  next_rdata[1:0] = busy;
            default:   next_err = 1'b1;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_apb <= '0;
        end else begin
            o_apb.pready  <= i_apb.psel && i_apb.penable && !o_apb.pready;
            o_apb.prdata  <= next_rdata;
            o_apb.pslverr <= next_err && i_apb.psel && i_apb.penable && !o_apb.pready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg                   <= psil_cfg_t'(CFG_RESET);
            port_irq_enable       <= IRQ_EN_RESET[1:0];
            write_done_irq_enable <= IRQ_EN_RESET[2];
        end else begin
            if (wr && (addr == OFS_CONFIG)) begin
                cfg <= psil_cfg_t'(wd[6:0]);
            end
            if (wr_irq_st) begin
                port_irq_enable       <= wd[IRQ_EN_B:IRQ_EN_A];
                write_done_irq_enable <= wd[IRQ_EN_DONE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1  <= '0;
            pin_s2  <= '0;
            strobe_pin_b_s1 <= 2'h0;
            strobe_pin_b_s2 <= 2'h0;
        end else begin
            pin_s1  <= i_port_pin;
            pin_s2  <= pin_s1;
            strobe_pin_b_s1 <= i_strobe_pin;
            strobe_pin_b_s2 <= strobe_pin_b_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-port latch, flag and strobe logic

    for (genvar p = 0; p < 2; p++) begin : g_port
        assign latch_clk[p] = strobe_pin_b_s2[p] ^ cfg.strobe_polarity_n[p];
        // an output port's strobe is driven, so it never clocks the latch
        assign cap_edge[p]  = !cfg.dir_out[p] && latch_clk[p] && !latch_clk_q[p];
        assign next_port_flag[p] = cap_edge[p] || (port_n_irq_flag[p] && !(
            (cfg.flag_clear_method && wr_irq_st && !wd[IRQ_FLAG_A + p]) ||
            (!cfg.flag_clear_method && rd_latch[p])));

        always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                latch_clk_q[p] <= 1'b0;
            end else begin
                latch_clk_q[p] <= latch_clk[p];
            end
        end

        always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                port_data_latch[p] <= 8'h00;
            end else if (cfg.dir_out[p]) begin
                if (wr_latch[p]) begin
                    port_data_latch[p] <= wd;
                end
            end else if (!latch_clk[p]) begin
                port_data_latch[p] <= pin_s2[p];
            end
        end

        always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                stb_cnt[p] <= 8'h00;
            end else if (wr_latch[p] && cfg.dir_out[p]) begin
                stb_cnt[p] <= 8'(STROBE_CYC);
            end else if (stb_cnt[p] != 8'h00) begin
                stb_cnt[p] <= stb_cnt[p] - 8'h01;
            end
        end

        always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                o_strobe_pin[p]    <= 1'b0;
                o_strobe_pin_oe[p] <= 1'b0;
                o_port_pin[p]      <= 8'h00;
                o_port_pin_oe[p]   <= 8'h00;
            end else begin
                // idle at the inactive level, pulse to the polarity level
                o_strobe_pin[p]    <= (stb_cnt[p] != 8'h00) ~^ cfg.strobe_polarity_n[p];
                o_strobe_pin_oe[p] <= cfg.dir_out[p];
                // open drain pulls low only; a 1 lets the pin serve as input
                o_port_pin[p]      <= cfg.wire_or[p] ? 8'h00 : port_data_latch[p];
                o_port_pin_oe[p]   <= !cfg.dir_out[p] ? 8'h00 :
                                      (cfg.wire_or[p] ? ~port_data_latch[p] : 8'hff);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags and interrupt request; a set in the clearing cycle wins

    assign next_write_done = prog_done ||
        (write_done_flag && !(wr_irq_st && !wd[IRQ_DONE]));

    logic next_irq;
    assign next_irq =
        |(next_port_flag & (wr_irq_st ? wd[IRQ_EN_B:IRQ_EN_A] : port_irq_enable)) ||
        (next_write_done && (wr_irq_st ? wd[IRQ_EN_DONE] : write_done_irq_enable));

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_n_irq_flag <= 2'h0;
            int_flag        <= 1'b0;
            write_done_flag <= 1'b0;
        end else begin
            port_n_irq_flag <= next_port_flag;
            int_flag        <= |next_port_flag;
            write_done_flag <= next_write_done;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_n    <= 1'b0;
            o_irq_n_oe <= 1'b0;
        end else begin
            o_irq_n    <= 1'b0;
            o_irq_n_oe <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // programming cycle and toggle status

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prog_reg <= 9'h000;
            toggle_q <= 1'b0;
        end else if (prog_start) begin
            prog_reg <= i_apb.pwdata[8:0];
            toggle_q <= ~i_apb.pwdata[TOGGLE_BIT];
        end else if (rd_prog && busy != 2'h0) begin
            toggle_q <= ~toggle_q;
        end
    end

    psil_prog_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_start   (prog_start),
        .i_plane   (i_apb.pwdata[PROG_PLANE]),
        .o_busy    (busy),
        .o_done    (prog_done)
    );

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_plane_busy <= 2'h0;
            o_prog_data  <= 9'h000;
        end else begin
            o_plane_busy <= busy;
            o_prog_data  <= prog_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_out_write_a;
        wr_latch[0] && cfg.dir_out[0];
    endsequence
    sequence s_pulse_a;
        (o_strobe_pin[0] == cfg.strobe_polarity_n[0])[*8];
    endsequence

    out_no_flag_a: assert property (cfg.dir_out[0] |=> !$rose(port_n_irq_flag[0]))
        else $error("output port raised its flag");
    capture_flag_a: assert property (cap_edge[0] |=>
        port_n_irq_flag[0] && int_flag && port_data_latch[0] == $past(pin_s2[0], 2))
        else $error("strobe edge did not latch and flag");
    irq_masked_a: assert property (
        (port_irq_enable == 2'h0 && !write_done_irq_enable && !wr_irq_st) |=> !o_irq_n_oe)
        else $error("masked interrupt request asserted");
    irq_release_a: assert property (
        (port_n_irq_flag == 2'h0 && !write_done_flag) |-> !o_irq_n_oe)
        else $error("request stays with no flag pending");
    write_clear_a: assert property ((cfg.flag_clear_method && port_n_irq_flag[0]
        && !cap_edge[0] && !wr_irq_st) |=> port_n_irq_flag[0])
        else $error("flag lost without a zero write");
    read_clear_a: assert property ((!cfg.flag_clear_method && rd_latch[0]
        && !cap_edge[0]) |=> !port_n_irq_flag[0])
        else $error("latch read did not clear flag");
    // an open-drain port with an all-ones latch drives no pin, so judge the strobe driver
    strobe_pulse_a: assert property (s_out_write_a |=> ##1 s_pulse_a ##0
        o_strobe_pin_oe[0])
        else $error("no strobe pulse after output write");
    toggle_bit_a: assert property ((rd_prog && busy != 2'h0) |=>
        toggle_q != $past(toggle_q))
        else $error("status bit did not toggle");
    write_done_a: assert property (prog_done |=> write_done_flag ##0
        o_plane_busy != 2'h0)
        else $error("write done flag not set");
    eow_irq_a: assert property ((prog_done && write_done_irq_enable && !wr_irq_st)
        |=> o_irq_n_oe ##0 !o_irq_n)
        else $error("write done did not request interrupt");
    eow_hold_a: assert property ((write_done_flag && !wr_irq_st) |=> write_done_flag)
        else $error("write done flag lost");

endmodule

// ### psil_periph.sv
`timescale 1ns/100ps
// far-side peripheral: drives port pins and strobes, resolves shared wires
module psil_periph (
    input  wire logic [1:0][7:0] i_dut_pin,
    input  wire logic [1:0][7:0] i_dut_pin_oe,
    input  wire logic [1:0]      i_dut_strobe,
    input  wire logic [1:0]      i_dut_strobe_oe,
    input  wire logic [1:0][7:0] i_ext_pin,
    input  wire logic [1:0]      i_ext_strobe,
    output logic      [1:0][7:0] o_pin,
    output logic      [1:0]      o_strobe
);
    import psil_pkg::*;
    // the bench holds i_ext_pin steady across every pin view read
    // where the device drives a bit it wins; elsewhere the peripheral drives
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            o_strobe[p] = i_dut_strobe_oe[p] ? i_dut_strobe[p] : i_ext_strobe[p];
            for (int b = 0; b < 8; b++) begin
                o_pin[p][b] = i_dut_pin_oe[p][b] ? i_dut_pin[p][b] : i_ext_pin[p][b];
            end
        end
    end
endmodule

// ### test_port_strobe_interrupt_logic.sv
`timescale 1ns/100ps
module test_port_strobe_interrupt_logic;
    import psil_pkg::*;
    // long enough that both toggle reads fall inside the programming cycle
    localparam int unsigned WC = 40;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    psil_apb_req_t req = '0;
    psil_apb_rsp_t rsp;
    logic [1:0][7:0] ext_pin = '0, pin, dpin, dpin_oe;
    logic [1:0] ext_strobe = '0, strobe, dstr, dstr_oe, busy;
    logic irq_n, irq_oe, slverr;
    logic [8:0] prog_data;
    logic [31:0] r1, r2;
    int num_errors = 0;
    int checked = 0;

    always #4 clk = ~clk;

    psil_top #(.WRITE_CYCLES(WC)) i_dut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_apb(req), .o_apb(rsp),
        .i_port_pin(pin), .o_port_pin(dpin), .o_port_pin_oe(dpin_oe),
        .i_strobe_pin(strobe), .o_strobe_pin(dstr), .o_strobe_pin_oe(dstr_oe),
        .o_irq_n(irq_n), .o_irq_n_oe(irq_oe), .o_plane_busy(busy),
        .o_prog_data(prog_data));

    psil_periph i_periph (
        .i_dut_pin(dpin), .i_dut_pin_oe(dpin_oe), .i_dut_strobe(dstr),
        .i_dut_strobe_oe(dstr_oe), .i_ext_pin(ext_pin),
        .i_ext_strobe(ext_strobe), .o_pin(pin), .o_strobe(strobe));

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // apb master: hold the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        slverr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, {24'h0, d}, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask

    task automatic irq_chk(input logic exp);
        cyc(2);
        check({irq_n, irq_oe}, {1'b0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic s_capture();
        rd_chk(OFS_CONFIG, 32'h0);
        wr(OFS_IRQ_STAT, 8'h10);
        ext_pin[0] <= 8'h5a;
        cyc(4);
        ext_strobe[0] <= 1'b1;
        cyc(6);
        ext_pin[0] <= 8'ha5;
        cyc(4);
        rd_chk(OFS_IRQ_STAT, 32'h15);
        irq_chk(1'b1);
        rd_chk(OFS_LATCH_A, 32'h5a);
        rd_chk(OFS_IRQ_STAT, 32'h10);
        irq_chk(1'b0);
    endtask

    task automatic s_freeze();
        ext_strobe[0] <= 1'b0;
        cyc(6);
        rd_chk(OFS_LATCH_A, 32'ha5);
        rd_chk(OFS_IRQ_STAT, 32'h10);
        wr(OFS_CONFIG, 8'h50);
        cyc(4);
        ext_pin[0] <= 8'h3c;
        cyc(5);
        rd_chk(OFS_LATCH_A, 32'ha5);
        rd_chk(OFS_IRQ_STAT, 32'h15);
        irq_chk(1'b1);
        wr(OFS_IRQ_STAT, 8'h11);
        rd_chk(OFS_IRQ_STAT, 32'h15);
        wr(OFS_IRQ_STAT, 8'h10);
        rd_chk(OFS_IRQ_STAT, 32'h10);
        irq_chk(1'b0);
    endtask

    task automatic s_mask();
        ext_strobe[1] <= 1'b1;
        cyc(6);
        rd_chk(OFS_IRQ_STAT, 32'h16);
        irq_chk(1'b0);
        wr(OFS_IRQ_STAT, 8'h32);
        irq_chk(1'b1);
        wr(OFS_IRQ_STAT, 8'h30);
        irq_chk(1'b0);
    endtask

    task automatic s_output();
        wr(OFS_CONFIG, 8'h51);
        wr(OFS_LATCH_A, 8'h3c);
        cyc(2);
        check({dpin[0], dpin_oe[0]}, 32'h3cff);
        check({dstr_oe[0], dstr[0]}, 32'h3);
        cyc(14);
        check(dstr[0], 32'h0);
        ext_strobe[0] <= 1'b1;
        cyc(6);
        rd_chk(OFS_IRQ_STAT, 32'h30);
        irq_chk(1'b0);
    endtask

    task automatic s_bidir();
        wr(OFS_CONFIG, 8'h55);
        wr(OFS_LATCH_A, 8'hf0);
        ext_pin[0] <= 8'h9f;
        cyc(4);
        check(dpin_oe[0], 32'h0f);
        rd_chk(OFS_PINS_A, 32'h90);
        check(dstr_oe[0], 32'h1);
        rd_chk(OFS_IRQ_STAT, 32'h30);
    endtask

    task automatic s_prog();
        wr(OFS_IRQ_STAT, 8'h40);
        apb(1'b1, OFS_PROG, 32'h155, r1);
        // a second byte while the upper plane programs must be ignored
        wr(OFS_PROG, 8'h55);
        cyc(2);
        check(busy, 32'h2);
        check(prog_data, 32'h155);
        rd_chk(OFS_STAT, 32'h2);
        apb(1'b0, OFS_PROG, 32'h0, r1);
        apb(1'b0, OFS_PROG, 32'h0, r2);
        check({r1[8:7], r1[5:0]}, {24'h0, 2'b10, 6'h15});
        check(r1[6] ^ r2[6], 32'h1);
        cyc(WC + 5);
        rd_chk(OFS_IRQ_STAT, 32'h48);
        irq_chk(1'b1);
        wr(OFS_IRQ_STAT, 8'h48);
        rd_chk(OFS_IRQ_STAT, 32'h48);
        wr(OFS_IRQ_STAT, 8'h40);
        rd_chk(OFS_IRQ_STAT, 32'h40);
        irq_chk(1'b0);
        apb(1'b0, 8'h20, 32'h0, r1);
        check(slverr, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("errors %0d, comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    initial begin
        cyc(5000);
        num_errors++;
        conclude();
    end

    initial begin
        cyc(4);
        rst_n <= 1'b1;
        rd_chk(OFS_IRQ_STAT, 32'h0);
        s_capture();
        s_freeze();
        s_mask();
        s_output();
        s_bidir();
        s_prog();
        conclude();
    end
endmodule
